// ### logic/eipl_top.sv
/*
  External interrupt pin logic: four maskable active-low interrupt lines
  with enable and flag registers, a global mode bit, and a shared
  non-maskable / watchdog pin chosen by a select register.
  Assumes a single AHB-Lite master, hclk at 50 MHz, and a core that
  takes irq_req/irq_vec and pulses irq_ack when it services them.
*/
// Summary of operation
// - Four maskable lines exist and each is taken only if its own enable bit is set.
// - A global mode bit in the core status register blocks all maskable lines when set.
// - Each line has a pending flag that software reads and clears by writing one.
// - Pending enabled requests are served in fixed order, non-maskable first then line 0 to 3.
// - The shared pin function is chosen by the timer signal select register.
// - After reset the shared pin acts as the non-maskable interrupt input.
// - The non-maskable interrupt ignores enables and the mode bit, but pin edges raise it only while the select register picks NMI.
// - With the watchdog selected the shared pin is driven and read as the watchdog signal.
`timescale 1ns/100ps
`default_nettype none
module eipl_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] ext_irq_n,
  input wire logic nmi_pin_in,
  output logic nmi_pin_out,
  output logic nmi_pin_oe,
  input wire logic wdt_out_level,
  output logic watchdog_pin_signal,
  output logic irq_req,
  output logic [2:0] irq_vec,
  input wire logic irq_ack
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_s;
  eipl_sync #(.W(5)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .async_in({nmi_pin_in, ext_irq_n}),
    .sync_out(pins_s)
  );
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0] irq_enable_reg_a_q, irq_enable_reg_a_d;
  logic [1:0] irq_enable_reg_b_q, irq_enable_reg_b_d;
  logic [3:0] flag_q, flag_d;
  logic global_irq_mask_bit_q, global_irq_mask_bit_d;
  logic sel_q, sel_d;
  logic [4:0] pins_prev_q, pins_prev_d;
  logic nmi_pend_q, nmi_pend_d;
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  eipl_pkg::eipl_state_t state_q, state_d;
  logic [2:0] vec_q, vec_d;
  // Fixed-priority pick; used for the request and for the status view
  function automatic logic [2:0] pick(input logic nmi, input logic [3:0] live);
    logic [2:0] v;
    v = eipl_pkg::VEC_NONE;
    if (nmi) begin
      v = eipl_pkg::VEC_NMI;
    end else if (live[0]) begin
      v = 3'h0;
    end else if (live[1]) begin
      v = 3'h1;
    end else if (live[2]) begin
      v = 3'h2;
    end else if (live[3]) begin
      v = 3'h3;
    end
    return v;
  endfunction
  logic [3:0] enables;
  logic [3:0] live;
  logic [3:0] fall;
  logic nmi_fall;
  logic [2:0] win;
  logic addr_ok;
  logic [31:0] wdata_eff;
  // ----------------------------------------------------------------
  // Combinational terms
  // ----------------------------------------------------------------
  always_comb begin
    enables = {irq_enable_reg_b_q, irq_enable_reg_a_q};
    live = flag_q & enables & {4{~global_irq_mask_bit_q}};
    fall = pins_prev_q[3:0] & ~pins_s[3:0];
    nmi_fall = pins_prev_q[4] & ~pins_s[4] & (sel_q == eipl_pkg::SEL_NMI);
    win = pick(nmi_pend_q, live);
    addr_ok = hsel & hready & htrans[1];
    wdata_eff = hwdata;
  end
  // Readback of one register
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] dflt);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == eipl_pkg::OFS_IER_A) begin
      r[1:0] = irq_enable_reg_a_q;
    end else if (a == eipl_pkg::OFS_IER_B) begin
      r[1:0] = irq_enable_reg_b_q;
    end else if (a == eipl_pkg::OFS_IFR_A) begin
      r[1:0] = flag_q[1:0];
    end else if (a == eipl_pkg::OFS_IFR_B) begin
      r[1:0] = flag_q[3:2];
    end else if (a == eipl_pkg::OFS_ST1) begin
      r[eipl_pkg::ST1_MODE_BIT] = global_irq_mask_bit_q;
    end else if (a == eipl_pkg::OFS_TSEL) begin
      r[eipl_pkg::SELECT_BIT] = sel_q;
    end else if (a == eipl_pkg::OFS_STAT) begin
      r[3:0] = pins_s[3:0];
      r[eipl_pkg::STAT_NMI_BIT] = nmi_pend_q;
      r[eipl_pkg::STAT_ACT_BIT] = (state_q == eipl_pkg::EIPL_REQ);
      r[eipl_pkg::STAT_VEC_LSB +: 3] = win;
    end else begin
      r = dflt;
    end
    return r;
  endfunction
  // ----------------------------------------------------------------
  // Next-state logic: bus, flags and service machine
  // ----------------------------------------------------------------
  always_comb begin
    irq_enable_reg_a_d = irq_enable_reg_a_q;
    irq_enable_reg_b_d = irq_enable_reg_b_q;
    flag_d = flag_q;
    global_irq_mask_bit_d = global_irq_mask_bit_q;
    sel_d = sel_q;
    pins_prev_d = pins_s;
    nmi_pend_d = nmi_pend_q;
    wr_pend_d = addr_ok & hwrite;
    wr_addr_d = haddr[7:0];
    hrdata_d = hrdata_q;
    state_d = state_q;
    vec_d = vec_q;
    // Register writes land in the data phase
    if (wr_pend_q) begin
      if (wr_addr_q == eipl_pkg::OFS_IER_A) begin
        irq_enable_reg_a_d = wdata_eff[1:0];
      end else if (wr_addr_q == eipl_pkg::OFS_IER_B) begin
        irq_enable_reg_b_d = wdata_eff[1:0];
      end else if (wr_addr_q == eipl_pkg::OFS_IFR_A) begin
        flag_d[1:0] = flag_q[1:0] & ~wdata_eff[1:0];
      end else if (wr_addr_q == eipl_pkg::OFS_IFR_B) begin
        flag_d[3:2] = flag_q[3:2] & ~wdata_eff[1:0];
      end else if (wr_addr_q == eipl_pkg::OFS_ST1) begin
        global_irq_mask_bit_d = wdata_eff[eipl_pkg::ST1_MODE_BIT];
      end else if (wr_addr_q == eipl_pkg::OFS_TSEL) begin
        sel_d = wdata_eff[eipl_pkg::SELECT_BIT];
      end
    end
    // Read data is fetched in the address phase so it stands for the data phase
    if (addr_ok && !hwrite) begin
      hrdata_d = rd_mux(haddr[7:0], 32'h0000_0000);
    end
    // Service machine: hold request until the core acknowledges
    case (state_q)
      eipl_pkg::EIPL_IDLE: begin
        if (win != eipl_pkg::VEC_NONE) begin
          state_d = eipl_pkg::EIPL_REQ;
          vec_d = win;
        end
      end
      eipl_pkg::EIPL_REQ: begin
        if (irq_ack) begin
          state_d = eipl_pkg::EIPL_IDLE;
          vec_d = eipl_pkg::VEC_NONE; // Idle shows no vector
          if (vec_q == eipl_pkg::VEC_NMI) begin
            nmi_pend_d = 1'b0;
          end else begin
            flag_d[vec_q[1:0]] = 1'b0;
          end
        end
      end
      default: state_d = eipl_pkg::EIPL_IDLE;
    endcase
    // Edges set last so a set beats a same-cycle clear
    flag_d = flag_d | fall;
    if (nmi_fall) begin
      nmi_pend_d = 1'b1;
    end
  end
  // Registers only; clk_en freezes everything
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_reg_a_q <= eipl_pkg::IER_RST;
      irq_enable_reg_b_q <= eipl_pkg::IER_RST;
      flag_q <= 4'h0;
      global_irq_mask_bit_q <= eipl_pkg::MODE_RST;
      sel_q <= eipl_pkg::SELECT_RST;
      pins_prev_q <= 5'h1F;
      nmi_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      state_q <= eipl_pkg::EIPL_IDLE;
      vec_q <= eipl_pkg::VEC_NONE;
    end else if (clk_en) begin
      irq_enable_reg_a_q <= irq_enable_reg_a_d;
      irq_enable_reg_b_q <= irq_enable_reg_b_d;
      flag_q <= flag_d;
      global_irq_mask_bit_q <= global_irq_mask_bit_d;
      sel_q <= sel_d;
      pins_prev_q <= pins_prev_d;
      nmi_pend_q <= nmi_pend_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q <= hrdata_d;
      state_q <= state_d;
      vec_q <= vec_d;
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait states; clk_en low stalls the bus so nothing is lost
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign irq_req = (state_q == eipl_pkg::EIPL_REQ);
  assign irq_vec = vec_q;
  // Shared pin: driven only in watchdog mode, otherwise an input
  assign nmi_pin_oe = (sel_q == eipl_pkg::SEL_WDT);
  assign nmi_pin_out = wdt_out_level & nmi_pin_oe;
  assign watchdog_pin_signal = pins_s[4] | (sel_q == eipl_pkg::SEL_NMI);
endmodule
`default_nettype wire

// ### pkg/eipl_pkg.sv
/*
  Package for the external interrupt pin logic: register offsets, field
  positions, reset values and encodings shared by the design files.
  Assumes a 32-bit AHB-Lite register bus and a 50 MHz core clock.
*/
package eipl_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IER_A = 8'h00;
  localparam logic [7:0] OFS_IER_B = 8'h04;
  localparam logic [7:0] OFS_IFR_A = 8'h08;
  localparam logic [7:0] OFS_IFR_B = 8'h0C;
  localparam logic [7:0] OFS_ST1 = 8'h10;
  localparam logic [7:0] OFS_TSEL = 8'h14;
  localparam logic [7:0] OFS_ACK = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Lines 0,1 live in register a bits 1:0; lines 2,3 in register b bits 1:0
  localparam int LINES_PER_REG = 2;
  localparam int NUM_LINES = 4;
  localparam int ST1_MODE_BIT = 11;
  localparam int SELECT_BIT = 0;
  localparam int STAT_NMI_BIT = 4;
  localparam int STAT_ACT_BIT = 5;
  localparam int STAT_VEC_LSB = 8;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] IER_RST = 2'h0;
  localparam logic MODE_RST = 1'b1;
  localparam logic SELECT_RST = 1'b0;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic SEL_NMI = 1'b0;
  localparam logic SEL_WDT = 1'b1;
  localparam logic [2:0] VEC_NMI = 3'h4;
  localparam logic [2:0] VEC_NONE = 3'h7;
  typedef enum logic [1:0] {
    EIPL_IDLE,
    EIPL_REQ
  } eipl_state_t;
endpackage

// ### logic/eipl_sync.sv
/*
  Two-flip-flop synchroniser for a vector of asynchronous pin levels.
  Assumes inputs come from outside the hclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module eipl_sync #(
  parameter int W = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  // ----------------------------------------------------------------
  // Next values; idle pins are high, so reset to high
  // ----------------------------------------------------------------
  always_comb begin
    meta_d = clk_en ? async_in : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
  end
  // Registers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### tb/eipl_asserts.sv
/*
  Checker for the external interrupt pin logic ports.
  Assumes one clock, hclk, and the asynchronous active-low hresetn.
*/
`timescale 1ns/100ps
`default_nettype none
module eipl_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic nmi_pin_out,
  input wire logic nmi_pin_oe,
  input wire logic wdt_out_level,
  input wire logic watchdog_pin_signal,
  input wire logic irq_req,
  input wire logic [2:0] irq_vec,
  input wire logic irq_ack
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // Bus and shared pin
  // ----------------------------------------------------------------
  a_ready_en: assert property (hreadyout == clk_en)
    else $error("hreadyout differs from clk_en");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  // Stable level guard lets a registered or direct drive both pass
  a_oe_drive: assert property (nmi_pin_oe && $stable(wdt_out_level) |->
    nmi_pin_out == wdt_out_level) else $error("pin not driven with watchdog level");
  a_nmi_mode_sig: assert property (!nmi_pin_oe |-> watchdog_pin_signal)
    else $error("watchdog signal not forced high in NMI mode");
  // ----------------------------------------------------------------
  // Request handshake
  // ----------------------------------------------------------------
  a_req_hold: assert property (irq_req && !irq_ack |=> irq_req && $stable(irq_vec))
    else $error("request dropped or changed before ack");
  a_ack_drop: assert property (irq_req && irq_ack && clk_en |=> !irq_req)
    else $error("request still high after ack");
  a_vec_range: assert property (irq_req |-> irq_vec <= 3'h4)
    else $error("request with bad vector");
  a_idle_vec: assert property (!irq_req |-> irq_vec == eipl_pkg::VEC_NONE)
    else $error("vector not none while idle");
  // Pin level reaches the watchdog two enabled edges later
  a_wdt_follow: assert property ($past(nmi_pin_oe, 2) && $past(clk_en) && $past(clk_en, 2)
    |-> watchdog_pin_signal == $past(nmi_pin_out, 2)) else $error("watchdog signal lags pin");
  c_line_req: cover property (irq_req && irq_vec == 3'h0);
  c_nmi_req: cover property (irq_req && irq_vec == eipl_pkg::VEC_NMI);
  c_wdt_mode: cover property (nmi_pin_oe);
endmodule
bind eipl_top eipl_chk u_eipl_chk (.hclk, .hresetn, .clk_en, .hreadyout, .hresp,
  .nmi_pin_out, .nmi_pin_oe, .wdt_out_level, .watchdog_pin_signal, .irq_req,
  .irq_vec, .irq_ack);
`default_nettype wire

// ### tb/eipl_src.sv
/*
  Interrupt sources and watchdog timer standing outside the block.
  Assumes the shared pin has an external pull-up when nobody drives it.
*/
`timescale 1ns/100ps
`default_nettype none
module eipl_src (
  input wire logic hclk,
  input wire logic [3:0] line_lo,
  input wire logic nmi_lo,
  input wire logic nmi_pin_out,
  input wire logic nmi_pin_oe,
  output logic [3:0] ext_irq_n,
  output logic nmi_pin_in,
  output var logic wdt_out_level
);
  logic [1:0] div_q = 2'h0;
  // Active-low sources, pulled high at rest
  assign ext_irq_n = ~line_lo;
  // Wire level: block drives when enabled, else the source or pull-up
  assign nmi_pin_in = nmi_pin_oe ? nmi_pin_out : ~nmi_lo;
  // Timer output toggles every four cycles
  initial wdt_out_level = 1'b1;
  always @(posedge hclk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) begin
      wdt_out_level <= ~wdt_out_level;
    end
  end
endmodule
`default_nettype wire

// ### tb/eipl_top_tb.sv
/*
  Self-checking bench for the external interrupt pin logic.
  Assumes zero-wait AHB-Lite answers and a one-cycle irq_ack pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module eipl_top_tb;
  logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic [3:0] ext_irq_n, line_lo = 4'h0;
  logic nmi_lo = 1'b0, irq_ack = 1'b0, hreadyout, hresp, nmi_pin_in, nmi_pin_out;
  logic nmi_pin_oe, wdt_out_level, watchdog_pin_signal, irq_req;
  logic [2:0] irq_vec;
  int num_errors = 0, comparisons = 0;
  eipl_top u_eipl_top (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .ext_irq_n, .nmi_pin_in, .nmi_pin_out, .nmi_pin_oe, .wdt_out_level,
    .watchdog_pin_signal, .irq_req, .irq_vec, .irq_ack);
  eipl_src u_eipl_src (.hclk, .line_lo, .nmi_lo, .nmi_pin_out, .nmi_pin_oe,
    .ext_irq_n, .nmi_pin_in, .wdt_out_level);
  initial forever #10 hclk = ~hclk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for hready sampled high
  task automatic wait_rdy;
    for (int n = 0; n < 40; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    num_errors++;
    wrap_up();
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= {24'h00_0000, a}; htrans <= 2'h2; hwrite <= w;
    wait_rdy();
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic pulse(input logic [3:0] l, input logic n);
    line_lo <= l; nmi_lo <= n;
    repeat (5) @(posedge hclk);
    line_lo <= 4'h0; nmi_lo <= 1'b0;
    repeat (5) @(posedge hclk);
  endtask
  // Waits for a request, checks its vector, acknowledges it
  task automatic serve(input logic [2:0] v);
    for (int n = 0; n < 12 && irq_req !== 1'b1; n++) @(posedge hclk);
    if (irq_req !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    chk({29'h0, irq_vec}, {29'h0, v});
    irq_ack <= 1'b1;
    @(posedge hclk);
    irq_ack <= 1'b0;
    #1 chk({31'h0, irq_req}, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    xfer(1'b0, eipl_pkg::OFS_IER_A, 0); chk(r & 32'h3, 32'h0);
    xfer(1'b0, eipl_pkg::OFS_ST1, 0); chk(r & 32'h0000_0800, 32'h0000_0800);
    xfer(1'b0, eipl_pkg::OFS_TSEL, 0); chk(r & 32'h1, 32'h0);
    chk({31'h0, nmi_pin_oe}, 32'h0);
    xfer(1'b1, 8'h18, 32'h0000_FFFF); xfer(1'b0, 8'h18, 0); chk(r, 32'h0);
    clk_en <= 1'b0; @(posedge hclk); #1 chk({31'h0, hreadyout}, 32'h0);
    clk_en <= 1'b1; @(posedge hclk);
  endtask
  task automatic t_masked;
    pulse(4'h2, 1'b0);
    xfer(1'b0, eipl_pkg::OFS_IFR_A, 0); chk(r & 32'h3, 32'h2);
    xfer(1'b1, eipl_pkg::OFS_IER_A, 32'h2); chk({31'h0, irq_req}, 32'h0);
    xfer(1'b1, eipl_pkg::OFS_ST1, 32'h0); serve(3'h1);
    xfer(1'b0, eipl_pkg::OFS_IFR_A, 0); chk(r & 32'h3, 32'h0);
  endtask
  task automatic t_order;
    xfer(1'b1, eipl_pkg::OFS_IER_B, 32'h3);
    pulse(4'hC, 1'b0);
    // Status: pins idle, request active, line 2 winning
    xfer(1'b0, eipl_pkg::OFS_STAT, 0); chk(r, 32'h0000_022F);
    serve(3'h2);
    serve(3'h3);
    pulse(4'h1, 1'b0);
    chk({31'h0, irq_req}, 32'h0);
    xfer(1'b0, eipl_pkg::OFS_IFR_A, 0); chk(r & 32'h3, 32'h1);
    xfer(1'b1, eipl_pkg::OFS_IFR_A, 32'h1);
    xfer(1'b0, eipl_pkg::OFS_IFR_A, 0); chk(r & 32'h3, 32'h0);
  endtask
  task automatic t_nmi_wdt;
    logic [1:0] h;
    h = 2'h0;
    xfer(1'b1, eipl_pkg::OFS_ST1, 32'h0000_0800);
    pulse(4'h0, 1'b1); serve(eipl_pkg::VEC_NMI);
    xfer(1'b1, eipl_pkg::OFS_TSEL, 32'h1);
    xfer(1'b0, eipl_pkg::OFS_TSEL, 0); chk(r & 32'h1, 32'h1);
    chk({31'h0, nmi_pin_oe}, 32'h1);
    pulse(4'h0, 1'b1); chk({31'h0, irq_req}, 32'h0);
    // Watchdog view trails the pin by two flops; sampled mid-cycle to avoid races
    repeat (2) begin
      @(negedge hclk);
      h = {h[0], nmi_pin_in};
    end
    for (int n = 0; n < 12; n++) begin
      @(negedge hclk);
      chk({31'h0, watchdog_pin_signal}, {31'h0, h[1]});
      h = {h[0], nmi_pin_in};
    end
    repeat (10) @(posedge hclk);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_masked();
    t_order();
    t_nmi_wdt();
    wrap_up();
  end
endmodule
`default_nettype wire
